// [hw/sosr_pkg.sv]
// =====================================================================
// Shared constants and types of the reference output register bank
package sosr_pkg;

  // ===================================================================
  // Geometry
  localparam int NUM_OUT = 8;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int PS_W = 11;
  localparam int FINE_W = 8;

  // ===================================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DLY [NUM_OUT] = '{
    8'h28, 8'h29, 8'h2a, 8'h38, 8'h39, 8'h48, 8'h49, 8'h58};
  localparam logic [7:0] IDX_DRV [NUM_OUT] = '{
    8'h2c, 8'h2d, 8'h2e, 8'h3c, 8'h3d, 8'h4c, 8'h4d, 8'h5c};
  localparam logic [7:0] IDX_EN = 8'h76;
  localparam logic [7:0] IDX_BIAS_TYPE = 8'h19;

  // ===================================================================
  // Writable bit masks and reset values
  localparam logic [7:0] DLY_MASK = 8'h7f;
  localparam logic [7:0] DRV_MASK = 8'hbc;
  localparam logic [7:0] EN_MASK = 8'hff;
  localparam logic [7:0] BT_MASK = 8'h80;
  localparam logic [7:0] DLY_RST = 8'h10;
  localparam logic [7:0] DRV_RST = 8'h00;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] BT_RST = 8'h00;

  // ===================================================================
  // Field positions
  localparam int FINE_LO_MSB = 6;
  localparam int FINE_LO_LSB = 5;
  localparam int SRC_BIT = 4;
  localparam int COARSE_MSB = 3;
  localparam int COARSE_LSB = 1;
  localparam int FINE_HI_BIT = 0;
  localparam int PD_BIT = 7;
  localparam int BIAS_BIT = 5;
  localparam int STYLE_BIT = 4;
  localparam int AMP_MSB = 3;
  localparam int AMP_LSB = 2;
  localparam int BT_BIT = 7;
  localparam int EN_TOP = 7;

  // ===================================================================
  // Delay steps in picoseconds
  localparam logic [PS_W-1:0] COARSE_STEP_PS = 11'h0a9;
  localparam logic [FINE_W-1:0] FINE_PS [8] = '{
    8'h00, 8'h19, 8'h32, 8'h4b, 8'h55, 8'h6e, 8'h87, 8'ha0};

  // ===================================================================
  // Per-output configuration and decoded control
  typedef struct packed {
    logic [REG_W-1:0] delay_src;
    logic [REG_W-1:0] drive;
    logic enable;
    logic bias_type;
  } sosr_cfg_type;

  typedef struct packed {
    logic active;
    logic src_sysref;
    logic bias_on;
    logic style;
    logic [1:0] amp;
    logic [PS_W-1:0] coarse_ps;
    logic [FINE_W-1:0] fine_ps;
    logic [PS_W-1:0] delay_ps;
  } sosr_ctl_type;

endpackage : sosr_pkg

// [hw/sosr_out_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// One reference output: decodes its configuration into controls
module sosr_out_ctrl
  import sosr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire sosr_cfg_type cfg,
  input wire logic chan_clk_s,
  input wire logic sysref_s,
  output sosr_ctl_type ctl,
  output logic ref_out
);

  // ===================================================================
  // Helpers
  // Gathers the split fine delay code from its register byte
  function automatic logic [2:0] fine_code(input logic [7:0] b);
    fine_code = {b[FINE_HI_BIT], b[FINE_LO_MSB:FINE_LO_LSB]};
  endfunction : fine_code

  // ===================================================================
  // Decode
  sosr_ctl_type next_ctl;
  logic pd;
  logic next_ref_out;
  logic [PS_W-1:0] coarse_code;

  // Power-down masks style, enable and amplitude
  assign pd = cfg.drive[PD_BIT];
  assign coarse_code = {8'h00, cfg.delay_src[COARSE_MSB:COARSE_LSB]};
  assign next_ctl.active = !pd && cfg.enable;
  assign next_ctl.src_sysref = cfg.delay_src[SRC_BIT];
  assign next_ctl.bias_on = cfg.drive[BIAS_BIT] && cfg.bias_type;
  assign next_ctl.style = !pd && cfg.drive[STYLE_BIT];
  assign next_ctl.amp = pd ? 2'h0 : cfg.drive[AMP_MSB:AMP_LSB];
  assign next_ctl.coarse_ps = coarse_code * COARSE_STEP_PS;
  assign next_ctl.fine_ps = FINE_PS[fine_code(cfg.delay_src)];
  assign next_ctl.delay_ps = next_ctl.coarse_ps
                             + {3'h0, next_ctl.fine_ps};

  // Source selection; a disabled output sits low
  assign next_ref_out = next_ctl.active
                        && (next_ctl.src_sysref ? sysref_s : chan_clk_s);

  // Control and output flip-flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl <= '0;
      ref_out <= 1'b0;
    end else begin
      ctl <= next_ctl;
      ref_out <= next_ref_out;
    end
  end

endmodule : sosr_out_ctrl
`default_nettype wire

// [hw/sosr_regs.sv]
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Source bit 0 routes the channel clock to the reference output.
// - Source bit 1, the reset value, routes the central SYSREF.
// - Coarse delay equals the 3-bit code times 169 ps.
// - Fine delay codes map to 0,25,50,75,85,110,135,160 ps.
// - Total SYSREF delay is coarse plus fine delay.
// - Bias bit clear, the reset value, gives no output bias.
// - Bias bit set biases to LVDS cross-point when bias type is 1.
// - Per-output bias bits are ignored while bias type is 0.
// - Power-down bit turns output off, masking style, enable, amplitude.
// - Enable bit 0 holds the output static low.
module sosr_regs
  import sosr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_OUT-1:0] chan_clk_in,
  input wire logic sysref_in,
  output sosr_ctl_type ctl_out [NUM_OUT],
  output logic [NUM_OUT-1:0] sync_ref_output
);

  // ===================================================================
  // Helpers
  // Looks up an index in a table of per-output indices
  function automatic logic [3:0] find_ch(
    input logic [7:0] idx,
    input logic [7:0] tbl [NUM_OUT]
  );
    find_ch = 4'h0;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (idx == tbl[i]) begin
        find_ch = {1'b1, 3'(i)};
      end
    end
  endfunction : find_ch

  // ===================================================================
  // Storage
  logic [REG_W-1:0] delay_src [NUM_OUT];
  logic [REG_W-1:0] drive [NUM_OUT];
  logic [REG_W-1:0] en;
  logic [REG_W-1:0] bias_type;

  // ===================================================================
  // Address decode
  logic [7:0] idx;
  logic aligned;
  logic [3:0] dly_sel;
  logic [3:0] drv_sel;
  logic dly_hit;
  logic drv_hit;
  logic en_hit;
  logic bt_hit;
  logic addr_ok;
  logic [2:0] dly_ch;
  logic [2:0] drv_ch;
  logic [REG_W-1:0] rd_byte;

  // Word index and register hits
  assign idx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign dly_sel = find_ch(idx, IDX_DLY);
  assign drv_sel = find_ch(idx, IDX_DRV);
  assign dly_hit = aligned && dly_sel[3];
  assign drv_hit = aligned && drv_sel[3];
  assign dly_ch = dly_sel[2:0];
  assign drv_ch = drv_sel[2:0];
  assign en_hit = aligned && (idx == IDX_EN);
  assign bt_hit = aligned && (idx == IDX_BIAS_TYPE);
  assign addr_ok = dly_hit || drv_hit || en_hit || bt_hit;

  // Read selection; stored reserved bits are always zero
  assign rd_byte = dly_hit ? delay_src[dly_ch] :
                   drv_hit ? drive[drv_ch] :
                   en_hit ? en :
                   bt_hit ? bias_type : 8'h00;

  // ===================================================================
  // APB handshake
  logic setup_rd;
  logic wr_fire;

  // Zero wait states; unmapped access answers with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign setup_rd = psel && !penable && !pwrite;
  assign wr_fire = psel && penable && pwrite && addr_ok;

  // Read data captured in the setup cycle, held through access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (setup_rd) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  // ===================================================================
  // Register writes, masked so reserved bits stay zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        delay_src[i] <= DLY_RST;
        drive[i] <= DRV_RST;
      end
      en <= EN_RST;
      bias_type <= BT_RST;
    end else if (wr_fire) begin
      if (dly_hit) begin
        delay_src[dly_ch] <= pwdata[7:0] & DLY_MASK;
      end else if (drv_hit) begin
        drive[drv_ch] <= pwdata[7:0] & DRV_MASK;
      end else if (en_hit) begin
        en <= pwdata[7:0] & EN_MASK;
      end else if (bt_hit) begin
        bias_type <= pwdata[7:0] & BT_MASK;
      end
    end
  end

  // ===================================================================
  // Pin synchronisers
  logic [NUM_OUT-1:0] chan_meta;
  logic [NUM_OUT-1:0] chan_s;
  logic sysref_meta;
  logic sysref_s;

  // Two flip-flops on each incoming clock or reference pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chan_meta <= '0;
      chan_s <= '0;
      sysref_meta <= 1'b0;
      sysref_s <= 1'b0;
    end else begin
      chan_meta <= chan_clk_in;
      chan_s <= chan_meta;
      sysref_meta <= sysref_in;
      sysref_s <= sysref_meta;
    end
  end

  // ===================================================================
  // Per-output decoders
  sosr_cfg_type cfg [NUM_OUT];

  generate
    for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
      // Enables sit with output A0 at the top bit
      assign cfg[g].delay_src = delay_src[g];
      assign cfg[g].drive = drive[g];
      assign cfg[g].enable = en[EN_TOP-g];
      assign cfg[g].bias_type = bias_type[BT_BIT];

      sosr_out_ctrl u_out (
        .clk(clk),
        .reset_n(reset_n),
        .cfg(cfg[g]),
        .chan_clk_s(chan_s[g]),
        .sysref_s(sysref_s),
        .ctl(ctl_out[g]),
        .ref_out(sync_ref_output[g])
      );
    end
  endgenerate

  // ===================================================================
  // Assertions on output A0 and the bus
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic [PS_W-1:0] coarse0;
  assign coarse0 = {8'h00, delay_src[0][COARSE_MSB:COARSE_LSB]};

  // Read of a delay register: setup then access
  sequence s_rd_dly;
    (setup_rd && dly_hit) ##1 (psel && penable);
  endsequence

  // Write of output A0 delay register taking effect
  sequence s_wr_dly0;
    (wr_fire && dly_hit && (dly_ch == 3'h0)) ##1 1'b1;
  endsequence

  property p_src_clk;
    !delay_src[0][SRC_BIT] |=> !ctl_out[0].src_sysref;
  endproperty
  a_src_clk: assert property (p_src_clk)
    else $error("output A0 not on channel clock");

  property p_src_sys;
    delay_src[0][SRC_BIT] |=> ctl_out[0].src_sysref;
  endproperty
  a_src_sys: assert property (p_src_sys)
    else $error("output A0 not on SYSREF");

  property p_coarse;
    1'b1 |=> ctl_out[0].coarse_ps == $past(coarse0) * COARSE_STEP_PS;
  endproperty
  a_coarse: assert property (p_coarse)
    else $error("coarse delay mismatch");

  property p_fine;
    s_wr_dly0 |=> ctl_out[0].fine_ps
      == FINE_PS[{$past(pwdata[0], 2), $past(pwdata[6:5], 2)}];
  endproperty
  a_fine: assert property (p_fine)
    else $error("fine delay code assembled wrong");

  property p_fine_kink;
    ({delay_src[0][FINE_HI_BIT], delay_src[0][6:5]} == 3'h4)
      |=> ctl_out[0].fine_ps == 8'h55;
  endproperty
  a_fine_kink: assert property (p_fine_kink)
    else $error("fine code 100 not 85 ps");

  property p_sum;
    ctl_out[0].delay_ps
      == ctl_out[0].coarse_ps + {3'h0, ctl_out[0].fine_ps};
  endproperty
  a_sum: assert property (p_sum)
    else $error("total delay not coarse plus fine");

  property p_bias_clr;
    !drive[0][BIAS_BIT] |=> !ctl_out[0].bias_on;
  endproperty
  a_bias_clr: assert property (p_bias_clr)
    else $error("bias on with bias bit clear");

  property p_bias_set;
    drive[0][BIAS_BIT] && bias_type[BT_BIT] |=> ctl_out[0].bias_on;
  endproperty
  a_bias_set: assert property (p_bias_set)
    else $error("bias missing");

  property p_bias_ign;
    !bias_type[BT_BIT] |=> !ctl_out[0].bias_on;
  endproperty
  a_bias_ign: assert property (p_bias_ign)
    else $error("bias applied with bias type 0");

  property p_pd;
    drive[0][PD_BIT] |=> !ctl_out[0].active && !ctl_out[0].style
      && (ctl_out[0].amp == 2'h0) && !sync_ref_output[0];
  endproperty
  a_pd: assert property (p_pd)
    else $error("powered-down output still driven");

  property p_dis;
    !en[EN_TOP] |=> !ctl_out[0].active ##0 !sync_ref_output[0];
  endproperty
  a_dis: assert property (p_dis)
    else $error("disabled output not low");

  property p_rd_zero;
    s_rd_dly |-> (prdata[7] == 1'b0) && (prdata[31:8] == 24'h000000);
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("reserved bits read nonzero");

  // Write to the enable register lands at the access edge
  sequence s_wr_en;
    wr_fire && en_hit;
  endsequence

  property p_wr_en;
    s_wr_en |=> en == $past(pwdata[7:0]);
  endproperty
  a_wr_en: assert property (p_wr_en)
    else $error("enable write lost");

  // Refused access leaves the enable and bias type registers alone
  property p_refused;
    psel && penable && pwrite && !addr_ok
      |=> (en == $past(en)) && (bias_type == $past(bias_type));
  endproperty
  a_refused: assert property (p_refused)
    else $error("refused write changed a register");

endmodule : sosr_regs
`default_nettype wire

// [bench/sosr_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench for the reference output register bank
module sosr_regs_tb
  import sosr_pkg::*;
;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_OUT-1:0] chan_clk_in = '0;
  logic sysref_in = 1'h0;
  sosr_ctl_type ctl_out [NUM_OUT];
  logic [NUM_OUT-1:0] sync_ref_output;
  int err_total = 0;
  int n_tests = 0;
  localparam int FINE_EXP [8] = '{0, 25, 50, 75, 85, 110, 135, 160};

  // Design under test
  sosr_regs dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_clk_in(chan_clk_in),
    .sysref_in(sysref_in), .ctl_out(ctl_out),
    .sync_ref_output(sync_ref_output)
  );

  // Free running clock
  always #2.5 clk = ~clk;

  // ==========================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
    input logic [7:0] d, output logic [DATA_W-1:0] r, output logic e);
    int k;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    k = 0;
    while (pready !== 1'h1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k >= 50) begin
      $display("mismatch pready expected 1 seen timeout");
      err_total++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [DATA_W-1:0] r;
    logic e;
    apb(1'h1, {idx, 2'h0}, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] x);
    logic [DATA_W-1:0] r;
    logic e;
    apb(1'h0, {idx, 2'h0}, 8'h00, r, e);
    chk("prdata", {24'h000000, x}, r);
    chk("pslverr", 0, e);
  endtask : rd

  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask : settle

  task automatic pins(input logic [7:0] c, input logic s);
    @(posedge clk);
    chan_clk_in <= c;
    sysref_in <= s;
    settle();
  endtask : pins

  // ==========================================
  // Scenarios
  task automatic t_reset();
    settle();
    for (int i = 0; i < NUM_OUT; i++) begin
      chk("src reset", 1, ctl_out[i].src_sysref);
      chk("bias reset", 0, ctl_out[i].bias_on);
      rd(IDX_DLY[i], 8'h10);
      rd(IDX_DRV[i], 8'h00);
    end
    rd(IDX_EN, 8'h00);
    rd(IDX_BIAS_TYPE, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_reserved();
    logic [DATA_W-1:0] r;
    logic e;
    for (int i = 0; i < NUM_OUT; i++) begin
      wr(IDX_DLY[i], 8'hff);
      rd(IDX_DLY[i], 8'h7f);
      wr(IDX_DRV[i], 8'hff);
      rd(IDX_DRV[i], 8'hbc);
      wr(IDX_DRV[i], 8'h00);
    end
    wr(IDX_BIAS_TYPE, 8'hff);
    rd(IDX_BIAS_TYPE, 8'h80);
    apb(1'h1, {8'h30, 2'h0}, 8'hff, r, e);
    chk("unmapped wr err", 1, e);
    apb(1'h0, {8'h30, 2'h0}, 8'h00, r, e);
    chk("unmapped rd err", 1, e);
    chk("unmapped rd data", 0, r);
    apb(1'h0, {IDX_EN, 2'h1}, 8'h00, r, e);
    chk("unaligned err", 1, e);
    $display("test reserved done");
  endtask : t_reserved

  task automatic t_delay();
    logic [2:0] c;
    logic [2:0] f;
    for (int i = 0; i < 64; i++) begin
      c = i[2:0];
      f = i[5:3];
      wr(IDX_DLY[7], {1'h0, f[1:0], 1'h1, c, f[2]});
      settle();
      chk("coarse", c * 169, ctl_out[7].coarse_ps);
      chk("fine", FINE_EXP[f], ctl_out[7].fine_ps);
      chk("total", c * 169 + FINE_EXP[f], ctl_out[7].delay_ps);
    end
    $display("test delay done");
  endtask : t_delay

  task automatic t_source();
    wr(IDX_EN, 8'h10);
    wr(IDX_DLY[3], 8'h00);
    pins(8'h08, 1'h0);
    chk("chan high", 1, sync_ref_output[3]);
    pins(8'h00, 1'h1);
    chk("chan low", 0, sync_ref_output[3]);
    wr(IDX_DLY[3], 8'h10);
    pins(8'h00, 1'h1);
    chk("sysref high", 1, sync_ref_output[3]);
    pins(8'h08, 1'h0);
    chk("sysref low", 0, sync_ref_output[3]);
    wr(IDX_EN, 8'hef);
    pins(8'h00, 1'h1);
    chk("off level", 0, sync_ref_output[3]);
    chk("off", 0, ctl_out[3].active);
    chk("on", 1, ctl_out[4].active);
    wr(IDX_EN, 8'h10);
    wr(IDX_DRV[3], 8'h9c);
    settle();
    chk("pd active", 0, ctl_out[3].active);
    chk("pd style", 0, ctl_out[3].style);
    chk("pd amp", 0, ctl_out[3].amp);
    chk("pd level", 0, sync_ref_output[3]);
    wr(IDX_DRV[3], 8'h1c);
    settle();
    chk("up active", 1, ctl_out[3].active);
    chk("up style", 1, ctl_out[3].style);
    chk("up amp", 3, ctl_out[3].amp);
    chk("up level", 1, sync_ref_output[3]);
    $display("test source done");
  endtask : t_source

  task automatic t_bias();
    wr(IDX_BIAS_TYPE, 8'h00);
    wr(IDX_DRV[5], 8'h20);
    wr(IDX_DRV[0], 8'h20);
    settle();
    chk("bias type off", 0, ctl_out[5].bias_on);
    chk("bias type off a0", 0, ctl_out[0].bias_on);
    wr(IDX_BIAS_TYPE, 8'h80);
    settle();
    chk("bias on", 1, ctl_out[5].bias_on);
    chk("bias on a0", 1, ctl_out[0].bias_on);
    wr(IDX_DRV[5], 8'h00);
    wr(IDX_DRV[0], 8'h00);
    settle();
    chk("bias clear", 0, ctl_out[5].bias_on);
    chk("bias clear a0", 0, ctl_out[0].bias_on);
    $display("test bias done");
  endtask : t_bias

  // Verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'h1;
    t_reset();
    t_reserved();
    t_delay();
    t_source();
    t_bias();
    conclude();
  end

  // Watchdog against a hang
  initial begin
    #200000;
    err_total++;
    conclude();
  end
endmodule : sosr_regs_tb
`default_nettype wire
